// file: rgb_pwm_pkg.sv
/*
  Package for the RGB duty-forming block: register offsets, control-register fields,
  reset values, field-mode enumeration, field widths and timing constants.
  Assumes nothing of its surroundings; imported by scope only.
*/
package rgb_pwm_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] RED_DUTY_LOW_ADDR = 8'h01;
  localparam logic [7:0] GREEN_DUTY_LOW_ADDR = 8'h02;
  localparam logic [7:0] BLUE_DUTY_LOW_ADDR = 8'h03;
  localparam logic [7:0] RED_DUTY_HIGH_ADDR = 8'h04;
  localparam logic [7:0] GREEN_DUTY_HIGH_ADDR = 8'h05;
  localparam logic [7:0] BLUE_DUTY_HIGH_ADDR = 8'h06;
  localparam logic [7:0] FIELD_CTRL_ADDR = 8'h07;

  // ************************************************************
  // control register fields and reset values
  // ************************************************************
  localparam int SPREAD_EN_BIT = 0;
  localparam int SPREAD_RANGE_BIT = 1;
  localparam int THERMAL_EN_BIT = 2;
  localparam int FIELD_MODE_LSB = 4;
  localparam int FIELD_MODE_MSB = 5;
  localparam logic [7:0] FIELD_CTRL_RESET = 8'h06;
  localparam logic [7:0] FIELD_CTRL_MASK = 8'h37;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_ONE_FIELD = 2'h0,
    MODE_SPLIT_4_8 = 2'h1,
    MODE_SPLIT_5_7 = 2'h2,
    MODE_SPLIT_6_6 = 2'h3
  } field_mode_t;

  // ************************************************************
  // duty widths and timing
  // ************************************************************
  localparam int DUTY_W = 12;
  localparam int LOW_NIBBLE_W = 4;
  localparam logic [11:0] DUTY_FULL = 12'hFFF;
  localparam int CLK_HZ = 25_000_000;
  localparam int SPREAD_FAST_HZ = 5_000;
  localparam int SPREAD_SLOW_HZ = 200;
  localparam int SPREAD_FAST_CYC = CLK_HZ / SPREAD_FAST_HZ;
  localparam int SPREAD_SLOW_CYC = CLK_HZ / SPREAD_SLOW_HZ;
  localparam int SPREAD_PCT = 15;
  localparam int PCT_FULL = 100;
  localparam int PWM_PERIOD_NOM = 4096;
endpackage

// file: duty_former.sv
/*
  Duty former: builds one channel's 12-bit duty from its low and high data registers
  according to the field mode. Purely combinational; assumes stable inputs.
*/
`timescale 1ns/1ps
module duty_former (
  input wire logic [7:0] lowReg, // colour / low-nibble register
  input wire logic [7:0] highReg, // luminance / high-byte register
  input wire rgb_pwm_pkg::field_mode_t mode, // field mode selector
  output logic [11:0] duty // formed duty value
);
  logic [5:0] colourField;
  logic [7:0] luminanceField;
  logic [13:0] product;

  // fields masked to the mode's width; upper bits ignored
  assign colourField = (mode == rgb_pwm_pkg::MODE_SPLIT_4_8) ? {2'h0, lowReg[3:0]} :
                       (mode == rgb_pwm_pkg::MODE_SPLIT_5_7) ? {1'h0, lowReg[4:0]} :
                       lowReg[5:0];
  assign luminanceField = (mode == rgb_pwm_pkg::MODE_SPLIT_4_8) ? highReg :
                          (mode == rgb_pwm_pkg::MODE_SPLIT_5_7) ? {1'h0, highReg[6:0]} :
                          {2'h0, highReg[5:0]};
  // product never exceeds 3969, so 12 bits hold it
  assign product = colourField * luminanceField;

  assign duty = (mode == rgb_pwm_pkg::MODE_ONE_FIELD) ?
                {highReg, lowReg[3:0]} :
                product[11:0];
endmodule

// file: rgb_pwm_field_mode_control.sv
/*
  Top of the RGB duty-forming block: register file at the documented offsets, duty
  forming per channel, PWM period counter with boundary-only duty load, current
  scaling from nonvolatile maximum current, thermal shutdown and spread-spectrum
  period dithering. Assumes a synchronous write/read port driven by the serial bus
  front end and a synchronous over-temperature indication from the analog side.
*/
`timescale 1ns/1ps
// Operation
// - one-field duty: upper register gives bits 11:4, lower bits 3:0 give 3:0
// - red uses 01h/04h, green 02h/05h, blue 03h/06h
// - one-field mode gives 4096 duty steps per channel
// - new duty values reach the running PWM only at period boundary
// - average current is channel maximum current scaled by duty
// - control bits 5:4 pick one-field, 4+8, 5+7 or 6+6 split
// - split 01: colour from low bits 3:0, luminance from all high bits
// - two-field duty is colour times luminance, max 15 times 255 in 4+8 split
// - split 10: colour low bits 4:0, luminance high bits 6:0
// - split 11: six-bit colour and luminance, max 63 times 63
// - with thermal enable set, drivers turn off above 165 C
// - thermal enable is control bit 2, resets to one
// - control bit 0 turns PWM clock spreading on, resets off
// - control bit 1 picks 5 kHz (0) or 200 Hz (1) spread rate; default parameters step the sweep once per PWM period at both
// - control register resets with bits 2 and 1 set, rest clear
// - output modulation mode picks 16-bit count or 8+8 dithered
module rgb_pwm_field_mode_control #(
  parameter int SPREAD_SLOW_CYCLES = rgb_pwm_pkg::SPREAD_SLOW_CYC, // 200 Hz sweep period
  parameter int SPREAD_FAST_CYCLES = rgb_pwm_pkg::SPREAD_FAST_CYC // 5 kHz sweep period
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic regWrite, // one-cycle write strobe
  input wire logic regRead, // one-cycle read strobe
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWrData, // write data
  output logic [7:0] regRdData, // read data, valid cycle after regRead
  input wire logic overTemp, // die above 165 C, synchronous
  input wire logic outputModulationMode, // 0 plain 16-bit, 1 8+8 dithered
  input wire logic [5:0] redMaxCurrent, // max current code from nonvolatile store
  input wire logic [5:0] greenMaxCurrent, // max current code from nonvolatile store
  input wire logic [5:0] blueMaxCurrent, // max current code from nonvolatile store
  output logic redOutput, // red driver enable
  output logic greenOutput, // green driver enable
  output logic blueOutput, // blue driver enable
  output logic [5:0] redCurrent, // red current code while on
  output logic [5:0] greenCurrent, // green current code while on
  output logic [5:0] blueCurrent, // blue current code while on
  output logic [11:0] redDuty, // red duty in use
  output logic [11:0] greenDuty, // green duty in use
  output logic [11:0] blueDuty, // blue duty in use
  output logic periodStart, // one-cycle pulse at each PWM boundary
  output logic thermalShutdown // drivers held off by over-temperature
);
  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] dutyLow_ff [3];
  logic [7:0] dutyHigh_ff [3];
  logic [7:0] fieldCtrl_ff;
  logic [7:0] nxt_regRdData;
  logic [2:0] lowSel;
  logic [2:0] highSel;
  logic ctrlSel;

  // one select per channel register, low and high apart
  assign lowSel[0] = regAddr == rgb_pwm_pkg::RED_DUTY_LOW_ADDR;
  assign lowSel[1] = regAddr == rgb_pwm_pkg::GREEN_DUTY_LOW_ADDR;
  assign lowSel[2] = regAddr == rgb_pwm_pkg::BLUE_DUTY_LOW_ADDR;
  assign highSel[0] = regAddr == rgb_pwm_pkg::RED_DUTY_HIGH_ADDR;
  assign highSel[1] = regAddr == rgb_pwm_pkg::GREEN_DUTY_HIGH_ADDR;
  assign highSel[2] = regAddr == rgb_pwm_pkg::BLUE_DUTY_HIGH_ADDR;
  assign ctrlSel = regAddr == rgb_pwm_pkg::FIELD_CTRL_ADDR;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        dutyLow_ff[i] <= rgb_pwm_pkg::DUTY_RESET;
        dutyHigh_ff[i] <= rgb_pwm_pkg::DUTY_RESET;
      end
    end else if (regWrite) begin
      for (int i = 0; i < 3; i++) begin
        if (lowSel[i]) begin
          dutyLow_ff[i] <= regWrData;
        end
        if (highSel[i]) begin
          dutyHigh_ff[i] <= regWrData;
        end
      end
    end
  end

  // reserved bits 7,6,3 never stored, read as zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fieldCtrl_ff <= rgb_pwm_pkg::FIELD_CTRL_RESET;
    end else if (regWrite && ctrlSel) begin
      fieldCtrl_ff <= regWrData & rgb_pwm_pkg::FIELD_CTRL_MASK;
    end
  end

  assign nxt_regRdData = (lowSel[0]) ? dutyLow_ff[0] :
                         (lowSel[1]) ? dutyLow_ff[1] :
                         (lowSel[2]) ? dutyLow_ff[2] :
                         (highSel[0]) ? dutyHigh_ff[0] :
                         (highSel[1]) ? dutyHigh_ff[1] :
                         (highSel[2]) ? dutyHigh_ff[2] :
                         (ctrlSel) ? fieldCtrl_ff : 8'h00;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= nxt_regRdData;
    end
  end

  // ************************************************************
  // control decode
  // ************************************************************
  rgb_pwm_pkg::field_mode_t fieldMode;
  logic spreadEnable;
  logic spreadRangeSelect;
  logic thermalShutdownEnable;

  assign fieldMode = rgb_pwm_pkg::field_mode_t'(
    fieldCtrl_ff[rgb_pwm_pkg::FIELD_MODE_MSB:rgb_pwm_pkg::FIELD_MODE_LSB]);
  assign spreadEnable = fieldCtrl_ff[rgb_pwm_pkg::SPREAD_EN_BIT];
  assign spreadRangeSelect = fieldCtrl_ff[rgb_pwm_pkg::SPREAD_RANGE_BIT];
  assign thermalShutdownEnable = fieldCtrl_ff[rgb_pwm_pkg::THERMAL_EN_BIT];

  // ************************************************************
  // duty forming
  // ************************************************************
  logic [11:0] formedDuty [3];

  for (genvar c = 0; c < 3; c++) begin : g_former
    duty_former u_former (
      .lowReg(dutyLow_ff[c]),
      .highReg(dutyHigh_ff[c]),
      .mode(fieldMode),
      .duty(formedDuty[c])
    );
  end

  // ************************************************************
  // spread-spectrum period dither
  // ************************************************************
  // triangular sweep of the PWM period between 85% and 115% of nominal;
  // steps wait for a period boundary, so the sweep runs slower than the spread modulation frequency
  localparam int SWEEP_W = 24;
  localparam int HALF_SPAN = rgb_pwm_pkg::PWM_PERIOD_NOM * rgb_pwm_pkg::SPREAD_PCT
                             / rgb_pwm_pkg::PCT_FULL;
  localparam logic [13:0] PERIOD_NOM = 14'(rgb_pwm_pkg::PWM_PERIOD_NOM);
  localparam logic [13:0] PERIOD_MIN = 14'(rgb_pwm_pkg::PWM_PERIOD_NOM - HALF_SPAN);
  localparam logic [13:0] PERIOD_MAX = 14'(rgb_pwm_pkg::PWM_PERIOD_NOM + HALF_SPAN);

  logic [SWEEP_W-1:0] sweepCnt_ff;
  logic [SWEEP_W-1:0] sweepLen;
  logic sweepUp_ff;
  logic [13:0] periodLen_ff;
  logic [13:0] nxt_periodLen;
  logic stepNow;

  // 4*HALF_SPAN steps per sweep period; slow rate when range bit set
  assign sweepLen = spreadRangeSelect ?
                    SWEEP_W'(SPREAD_SLOW_CYCLES / (4 * HALF_SPAN)) :
                    SWEEP_W'(SPREAD_FAST_CYCLES / (4 * HALF_SPAN));
  assign stepNow = periodStart && (sweepCnt_ff >= sweepLen);

  always_comb begin
    nxt_periodLen = periodLen_ff;
    if (!spreadEnable) begin
      nxt_periodLen = PERIOD_NOM;
    end else if (stepNow) begin
      nxt_periodLen = sweepUp_ff ? periodLen_ff + 14'h1 : periodLen_ff - 14'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sweepCnt_ff <= '0;
      sweepUp_ff <= 1'b1;
      periodLen_ff <= PERIOD_NOM;
    end else begin
      sweepCnt_ff <= stepNow ? '0 : sweepCnt_ff + SWEEP_W'(1);
      periodLen_ff <= nxt_periodLen;
      if (stepNow && (nxt_periodLen >= PERIOD_MAX)) begin
        sweepUp_ff <= 1'b0;
      end else if (stepNow && (nxt_periodLen <= PERIOD_MIN)) begin
        sweepUp_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // PWM period and boundary load
  // ************************************************************
  // duty is compared against the period scaled to 12 bits, so 4096 steps
  // hold at every dithered period length; 8+8 mode spreads the low byte
  // across 256 successive periods, counted by subCnt_ff
  logic [13:0] phase_ff;
  logic [11:0] phaseScaled;
  logic [7:0] subCnt_ff;
  logic boundary;

  assign boundary = phase_ff >= (periodLen_ff - 14'h1);
  assign phaseScaled = 12'((26'(phase_ff) * 26'(rgb_pwm_pkg::PWM_PERIOD_NOM))
                           / 26'(periodLen_ff));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= '0;
      subCnt_ff <= 8'h00;
      periodStart <= 1'b0;
    end else begin
      phase_ff <= boundary ? 14'h0 : phase_ff + 14'h1;
      subCnt_ff <= boundary ? subCnt_ff + 8'h1 : subCnt_ff;
      periodStart <= boundary;
    end
  end

  // shadow duties change only at a period boundary
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      redDuty <= 12'h000;
      greenDuty <= 12'h000;
      blueDuty <= 12'h000;
    end else if (boundary) begin
      redDuty <= formedDuty[0];
      greenDuty <= formedDuty[1];
      blueDuty <= formedDuty[2];
    end
  end

  // 16-bit view: duty << 4; in 8+8 mode the high byte sets the base width
  // and the low byte adds one step in that many of 256 successive periods
  function automatic logic pwmOn(input logic [11:0] d, input logic [11:0] ph,
                                 input logic [7:0] sub, input logic dith);
    logic [7:0] baseW;
    logic extra;
    baseW = d[11:4];
    extra = ({d[3:0], 4'h0} > sub);
    if (dith) begin
      pwmOn = (ph[11:4] < baseW) || ((ph[11:4] == baseW) && extra);
    end else begin
      pwmOn = ph < d;
    end
  endfunction

  // ************************************************************
  // thermal shutdown and outputs
  // ************************************************************
  logic shutdownNow;
  assign shutdownNow = thermalShutdownEnable && overTemp;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      thermalShutdown <= 1'b0;
      redOutput <= 1'b0;
      greenOutput <= 1'b0;
      blueOutput <= 1'b0;
      redCurrent <= 6'h00;
      greenCurrent <= 6'h00;
      blueCurrent <= 6'h00;
    end else begin
      thermalShutdown <= shutdownNow;
      redOutput <= !shutdownNow && pwmOn(redDuty, phaseScaled, subCnt_ff, outputModulationMode);
      greenOutput <= !shutdownNow &&
                     pwmOn(greenDuty, phaseScaled, subCnt_ff, outputModulationMode);
      blueOutput <= !shutdownNow &&
                    pwmOn(blueDuty, phaseScaled, subCnt_ff, outputModulationMode);
      // average current = max current times on-fraction
      redCurrent <= shutdownNow ? 6'h00 : redMaxCurrent;
      greenCurrent <= shutdownNow ? 6'h00 : greenMaxCurrent;
      blueCurrent <= shutdownNow ? 6'h00 : blueMaxCurrent;
    end
  end
endmodule

// file: rgb_pwm_chk.sv
/* checker: read port, duty load, thermal and period relations of the duty block
   assumes: bound onto the top; max current codes held static by the bench */
`timescale 1ns/1ps
module rgb_pwm_chk (
  input wire logic mclk, // clock
  input wire logic reset_n, // async reset
  input wire logic regRead, // read strobe
  input wire logic [7:0] regAddr, // address
  input wire logic [7:0] regRdData, // read data
  input wire logic overTemp, // hot die
  input wire logic [5:0] redMaxCurrent, // red max code
  input wire logic redOutput, // red on
  input wire logic greenOutput, // green on
  input wire logic blueOutput, // blue on
  input wire logic [5:0] redCurrent, // red code
  input wire logic [11:0] redDuty, // red duty
  input wire logic [11:0] greenDuty, // green duty
  input wire logic periodStart, // boundary pulse
  input wire logic thermalShutdown // drivers off
);
  // ********
  // period length tracker
  // ********
  logic [15:0] gapCnt_ff;
  logic seenFirst_ff;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gapCnt_ff <= 16'h0000;
      seenFirst_ff <= 1'b0;
    end else begin
      gapCnt_ff <= periodStart ? 16'h0001 : gapCnt_ff + 16'h0001;
      seenFirst_ff <= seenFirst_ff | periodStart;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ********
  // properties
  // ********
  // spread may stretch the period 85..115 percent of 4096
  period_length_a: assert property (periodStart && seenFirst_ff |->
    gapCnt_ff >= 16'h0D99 && gapCnt_ff <= 16'h1267) else $error("period out of range");
  single_pulse_a: assert property (periodStart |=> !periodStart)
    else $error("boundary pulse too long");
  boundary_load_a: assert property ($changed(redDuty) || $changed(greenDuty) |-> periodStart)
    else $error("duty changed mid period");
  zero_dark_a: assert property (redDuty == 12'h000 && $past(redDuty) == 12'h000 |-> !redOutput)
    else $error("red on at zero duty");
  shutdown_dark_a: assert property (thermalShutdown ##1 thermalShutdown |->
    !(redOutput || greenOutput || blueOutput)) else $error("driver on in shutdown");
  shutdown_cause_a: assert property (thermalShutdown |-> $past(overTemp))
    else $error("shutdown without heat");
  current_full_a: assert property (redOutput && !thermalShutdown |-> redCurrent == redMaxCurrent)
    else $error("red current not max");
  read_holds_a: assert property ($changed(regRdData) |-> $past(regRead))
    else $error("read data moved");
  unmapped_zero_a: assert property (regRead && (regAddr == 8'h00 || regAddr > 8'h07) |=>
    regRdData == 8'h00) else $error("unmapped read not zero");
endmodule
bind rgb_pwm_field_mode_control rgb_pwm_chk chk (.mclk, .reset_n, .regRead, .regAddr,
  .regRdData, .overTemp, .redMaxCurrent, .redOutput, .greenOutput, .blueOutput, .redCurrent,
  .redDuty, .greenDuty, .periodStart, .thermalShutdown);

// file: rgb_pwm_host.sv
/* host model: writes and reads the duty block registers
   assumes: one-cycle strobes, read data valid the cycle after the read edge */
`timescale 1ns/1ps
module rgb_pwm_host (
  input wire logic mclk, // clock
  output logic regWrite, // write strobe
  output logic regRead, // read strobe
  output logic [7:0] regAddr, // address
  output logic [7:0] regWrData, // write data
  input wire logic [7:0] regRdData // read data
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // ********
  // access tasks
  // ********
  // idle address and data are inverted so stale values cannot pass for fresh ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
  // fast spread only with plain 16-bit output, slow only with 8+8
  task automatic setCtrl(input logic [1:0] md, input logic th, input logic on, input logic dith);
    wr(8'h07, {2'b00, md, 1'b0, th, dith, on});
  endtask
  // equal luminance on all three keeps the mixed colour
  task automatic dimAll(input logic [7:0] lum);
    wr(8'h04, lum);
    wr(8'h05, lum);
    wr(8'h06, lum);
  endtask
endmodule

// file: tb_rgb_pwm_field_mode_control.sv
/* testbench: register access, field modes, period, spread and thermal shutdown
   assumes: host model drives the register port; fast spread sweep shortened, slow lengthened */
`timescale 1ns/1ps
module tb_rgb_pwm_field_mode_control;
  logic mclk, reset_n, regWrite, regRead, overTemp, outputModulationMode, moved;
  logic [7:0] regAddr, regWrData, regRdData, rdv, hi;
  logic [5:0] redMaxCurrent, greenMaxCurrent, blueMaxCurrent;
  logic [5:0] redCurrent, greenCurrent, blueCurrent;
  logic redOutput, greenOutput, blueOutput, periodStart, thermalShutdown;
  logic [11:0] redDuty, greenDuty, blueDuty;
  int error_cnt = 0;
  int samples_checked = 0;
  int len, onCnt, onGb;
  // fast sweep shortened, slow sweep lengthened: fast rate steps every period, slow rate every second period
  rgb_pwm_field_mode_control #(.SPREAD_SLOW_CYCLES(12280000), .SPREAD_FAST_CYCLES(1230)) dut (
    .mclk, .reset_n, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .overTemp,
    .outputModulationMode, .redMaxCurrent, .greenMaxCurrent, .blueMaxCurrent, .redOutput,
    .greenOutput, .blueOutput, .redCurrent, .greenCurrent, .blueCurrent, .redDuty,
    .greenDuty, .blueDuty, .periodStart, .thermalShutdown);
  rgb_pwm_host host (.mclk, .regWrite, .regRead, .regAddr, .regWrData, .regRdData);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ********
  // helpers
  // ********
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkIn(input int v, input int lo, input int up, input string m);
    samples_checked++;
    if (v < lo || v > up) begin
      error_cnt++;
      $display("unexpected %0t %s got %0d", $time, m, v);
    end
  endtask
  function automatic logic [11:0] form(input logic [1:0] md, input logic [7:0] lo,
                                       input logic [7:0] h);
    case (md)
      2'h0: return {h, lo[3:0]};
      2'h1: return {8'h00, lo[3:0]} * {4'h0, h};
      2'h2: return {7'h00, lo[4:0]} * {5'h00, h[6:0]};
      default: return {6'h00, lo[5:0]} * {6'h00, h[5:0]};
    endcase
  endfunction
  task automatic waitPs();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (periodStart !== 1'b1 && n < 6000);
    if (n >= 6000) chk(12'h000, 12'h001, "no boundary");
  endtask
  // called at a boundary; counts one period and the red on-time in it
  task automatic measure();
    len = 0;
    onCnt = 0;
    onGb = 0;
    do begin
      @(posedge mclk);
      len++;
      onCnt += int'(redOutput);
      onGb += int'(greenOutput) + int'(blueOutput);
    end while (periodStart !== 1'b1 && len < 6000);
  endtask
  // length changes over four periods tell the sweep rate apart
  task automatic spreadCheck(input int loSteps, input int hiSteps);
    int prev;
    int steps;
    moved = 1'b0;
    steps = 0;
    prev = 0;
    waitPs();
    for (int i = 0; i < 4; i++) begin
      measure();
      chkIn(len, 3481, 4711, "spread period");
      if (len != 4096) moved = 1'b1;
      if (i > 0 && len != prev) steps++;
      prev = len;
    end
    chk(moved, 1'b1, "no spread");
    chkIn(steps, loSteps, hiSteps, "spread rate");
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    reset_n = 1'b0;
    overTemp = 1'b0;
    outputModulationMode = 1'b0;
    redMaxCurrent = 6'h2A;
    greenMaxCurrent = 6'h15;
    blueMaxCurrent = 6'h3F;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      host.rd(8'(a), rdv);
      chk(rdv, (a == 7) ? 8'h06 : 8'h00, "reset value");
    end
    chk(redDuty, 12'h000, "reset duty");
    host.wr(8'h07, 8'hFF);
    host.rd(8'h07, rdv);
    chk(rdv, 8'h37, "control bits");
    for (int m = 0; m < 4; m++) begin
      hi = (m == 0) ? 8'hAB : 8'hFF;
      host.setCtrl(2'(m), 1'b1, 1'b0, 1'b0);
      for (int c = 0; c < 3; c++) host.wr(8'(1 + c), 8'hFF - 8'(c));
      host.dimAll(hi);
      waitPs();
      waitPs();
      chk(redDuty, form(2'(m), 8'hFF, hi), "red duty");
      chk(greenDuty, form(2'(m), 8'hFE, hi), "green duty");
      chk(blueDuty, form(2'(m), 8'hFD, hi), "blue duty");
      if (m == 0) begin
        measure();
        chkIn(len, 4096, 4096, "period");
        chkIn(onCnt, 2751, 2751, "on time");
        chk(redCurrent, redMaxCurrent, "red current");
        chkIn(onGb, 5499, 5499, "green blue on time");
        chk(greenCurrent, greenMaxCurrent, "green current");
        chk(blueCurrent, blueMaxCurrent, "blue current");
      end
    end
    host.setCtrl(2'h0, 1'b1, 1'b1, 1'b0);
    spreadCheck(3, 3);
    outputModulationMode <= 1'b1;
    host.setCtrl(2'h0, 1'b1, 1'b1, 1'b1);
    spreadCheck(1, 2);
    overTemp <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(thermalShutdown, 1'b1, "shutdown");
    chk({redOutput, greenOutput, blueOutput}, 3'h0, "drivers on");
    chk(redCurrent, 6'h00, "current in shutdown");
    chk({greenCurrent, blueCurrent}, 12'h000, "gb current in shutdown");
    host.setCtrl(2'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    chk(thermalShutdown, 1'b0, "shutdown disabled");
    end_of_test();
  end
  initial begin
    #4000000;
    error_cnt++;
    end_of_test();
  end
endmodule
